// ===== rtl/dmbi_codec.sv
/*
 Byte mask and bus inversion logic of one channel. Holds the two mode bits
 and the mask-disable bit behind a plain register port, samples the link
 clock, data and mask/invert pins with clk_sys, and encodes or decodes one
 beat per link edge. Assumes the command decoder starts each burst with
 op_start and that the array side delivers rd_data and takes wr_* at once.
*/
`include "dmbi_defines.svh"

module dmbi_codec
	import dmbi_pkg::*;
#(
	parameter int LANES = 2,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic op_start,
	input wire dmbi_op_type op_kind,
	input wire logic [5:0] op_beats,
	output logic busy,
	input wire logic link_clk,
	input wire logic [8*LANES-1:0] dq_in,
	output logic [8*LANES-1:0] dq_out,
	output logic dq_oe,
	input wire logic [LANES-1:0] mask_invert_in,
	output logic [LANES-1:0] mask_invert_out,
	output logic [LANES-1:0] mask_invert_oe,
	output logic mask_invert_rx_en,
	output logic wr_valid,
	output logic [8*LANES-1:0] wr_data,
	output logic [LANES-1:0] wr_byte_en,
	input wire logic [8*LANES-1:0] rd_data,
	input wire logic [LANES-1:0] rd_train_pattern,
	output logic rd_take
);
	localparam int DW = 8 * LANES;
	localparam int IW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

	if (LANES != 2) begin : g_lane_check
		$error("dmbi_codec serves exactly two byte lanes per channel");
	end
	if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_depth_check
		$error("dmbi_codec FIFO_DEPTH must be a power of two, at least 2");
	end

	logic [7:0] inv_mode;
	logic [7:0] mask_mode;
	logic illegal_seen;
	logic winv_en;
	logic rinv_en;
	logic mask_en;

	dmbi_state_type state;
	dmbi_op_type cur_kind;
	logic cur_winv;
	logic cur_rinv;
	logic cur_mask;
	logic [5:0] beats_left;
	logic [IW-1:0] fifo_idx;
	logic [DW+LANES-1:0] fifo_mem [FIFO_DEPTH];

	logic lk_s1, lk_s2, lk_s3;
	logic [DW-1:0] dq_s1, dq_s2;
	logic [LANES-1:0] mi_s1, mi_s2;
	logic link_edge;
	logic beat;
	logic op_take;
	logic cur_rx;
	logic is_write_kind;
	logic is_read_kind;
	logic [LANES-1:0] pin_cap;
	logic [DW+LANES-1:0] fifo_word;
	logic [DW-1:0] rd_src;
	logic [LANES-1:0] rd_pat;
	logic [DW-1:0] lane_wr;
	logic [LANES-1:0] lane_keep;
	logic [DW-1:0] lane_rd;
	logic [LANES-1:0] lane_pin;
	logic next_mi_oe;

	// Mask enable is the inverse of the stored disable bit
	assign winv_en = inv_mode[`DMBI_WINV_BIT]; // see R01
	assign rinv_en = inv_mode[`DMBI_RINV_BIT]; // see R02
	assign mask_en = ~mask_mode[`DMBI_MASK_DIS_BIT]; // see R03

	// Register port
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			inv_mode <= `DMBI_INV_MODE_RESET;
			mask_mode <= `DMBI_MASK_MODE_RESET;
		end else if (clk_en && reg_wr) begin
			if (reg_addr == `DMBI_REG_INV_MODE) begin
				inv_mode <= reg_wdata[7:0];
			end
			if (reg_addr == `DMBI_REG_MASK_MODE) begin
				mask_mode <= reg_wdata[7:0];
			end
		end
	end

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			illegal_seen <= 1'b0;
		end else if (clk_en) begin
			if (op_take && op_kind == DMBI_OP_MASKED_WRITE && !mask_en) begin
				illegal_seen <= 1'b1; // see R08
			end else if (reg_wr && reg_addr == `DMBI_REG_STATUS && reg_wdata[`DMBI_STAT_ILLEGAL_BIT]) begin
				illegal_seen <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 32'h0;
		end else if (clk_en) begin
			reg_rdata <= 32'h0;
			if (reg_rd) begin
				case (reg_addr)
					`DMBI_REG_INV_MODE: reg_rdata <= {24'h0, inv_mode};
					`DMBI_REG_MASK_MODE: reg_rdata <= {24'h0, mask_mode};
					`DMBI_REG_STATUS: begin
						reg_rdata[`DMBI_STAT_BUSY_BIT] <= busy;
						reg_rdata[`DMBI_STAT_ILLEGAL_BIT] <= illegal_seen;
						reg_rdata[`DMBI_STAT_BEATS_MSB:`DMBI_STAT_BEATS_LSB] <= beats_left;
					end
					default: reg_rdata <= 32'h0;
				endcase
			end
		end
	end

	// Pin synchronisers; the third link stage only feeds edge detection
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			lk_s1 <= 1'b0;
			lk_s2 <= 1'b0;
			lk_s3 <= 1'b0;
			dq_s1 <= '0;
			dq_s2 <= '0;
			mi_s1 <= '0;
			mi_s2 <= '0;
		end else if (clk_en) begin
			lk_s1 <= link_clk;
			lk_s2 <= lk_s1;
			lk_s3 <= lk_s2;
			dq_s1 <= dq_in;
			dq_s2 <= dq_s1;
			mi_s1 <= mask_invert_in;
			mi_s2 <= mi_s1;
		end
	end

	// Both link edges carry a beat
	assign link_edge = lk_s2 ^ lk_s3; // see R05
	assign beat = clk_en && link_edge && state == DMBI_BURST;
	assign op_take = clk_en && op_start && state == DMBI_IDLE && op_beats != 6'h0;
	assign cur_rx = cur_winv || cur_mask;
	assign is_write_kind = cur_kind == DMBI_OP_WRITE || cur_kind == DMBI_OP_MASKED_WRITE;
	assign is_read_kind = cur_kind == DMBI_OP_READ || cur_kind == DMBI_OP_MODE_REG_READ
		|| cur_kind == DMBI_OP_RD_FIFO || cur_kind == DMBI_OP_RD_TRAIN;
	assign pin_cap = cur_rx ? mi_s2 : '0; // see R06
	assign fifo_word = fifo_mem[fifo_idx];
	assign rd_src = cur_kind == DMBI_OP_RD_FIFO ? fifo_word[DW-1:0] : rd_data;
	assign rd_pat = cur_kind == DMBI_OP_RD_FIFO ? fifo_word[DW+LANES-1:DW] : rd_train_pattern;

	always_comb begin
		case (op_kind)
			DMBI_OP_READ, DMBI_OP_MODE_REG_READ: next_mi_oe = rinv_en; // see R07 see R18
			DMBI_OP_RD_FIFO, DMBI_OP_RD_TRAIN: next_mi_oe = winv_en || rinv_en || mask_en; // see R07
			default: next_mi_oe = 1'b0;
		endcase
	end

	for (genvar g = 0; g < LANES; g++) begin : g_lane
		dmbi_lane u_lane (
			.kind(cur_kind),
			.winv_en(cur_winv),
			.rinv_en(cur_rinv),
			.mask_en(cur_mask),
			.wr_byte(dq_s2[8*g +: 8]), // see R19
			.wr_pin(pin_cap[g]),
			.rd_byte(rd_src[8*g +: 8]),
			.rd_pattern_pin(rd_pat[g]),
			.wr_out(lane_wr[8*g +: 8]),
			.wr_keep(lane_keep[g]),
			.rd_out(lane_rd[8*g +: 8]),
			.rd_pin(lane_pin[g])
		);
	end

	// Burst sequencing; mode bits are frozen for the whole burst
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state <= DMBI_IDLE;
			cur_kind <= DMBI_OP_WRITE;
			cur_winv <= 1'b0;
			cur_rinv <= 1'b0;
			cur_mask <= 1'b0;
			beats_left <= 6'h0;
			busy <= 1'b0;
		end else if (clk_en) begin
			case (state)
				DMBI_IDLE: begin
					if (op_take) begin
						state <= DMBI_BURST;
						cur_kind <= op_kind;
						cur_winv <= winv_en;
						cur_rinv <= rinv_en;
						cur_mask <= mask_en;
						beats_left <= op_beats;
						busy <= 1'b1;
					end
				end
				DMBI_BURST: begin
					if (link_edge) begin
						beats_left <= beats_left - 6'h1;
						if (beats_left == 6'h1) begin
							// Reads keep driving the last beat until the next edge
							state <= is_read_kind ? DMBI_TAIL : DMBI_IDLE;
							busy <= is_read_kind;
						end
					end
				end
				DMBI_TAIL: begin
					if (link_edge) begin
						state <= DMBI_IDLE;
						busy <= 1'b0;
					end
				end
				default: state <= DMBI_IDLE;
			endcase
		end
	end

	// Receiver follows the live mode so it is off between bursts too
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			mask_invert_rx_en <= 1'b0;
		end else if (clk_en) begin
			mask_invert_rx_en <= winv_en || mask_en; // see R06
		end
	end

	// Training pattern store, raw data and the captured pin, zero when write inversion and masking are both off
	always_ff @(posedge clk_sys) begin
		if (beat && cur_kind == DMBI_OP_WR_FIFO) begin
			fifo_mem[fifo_idx] <= {pin_cap, dq_s2}; // see R15
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			fifo_idx <= '0;
		end else if (clk_en) begin
			if (op_take) begin
				fifo_idx <= '0;
			end else if (beat && (cur_kind == DMBI_OP_WR_FIFO || cur_kind == DMBI_OP_RD_FIFO)) begin
				fifo_idx <= fifo_idx + IW'(1); // see R16
			end
		end
	end

	// Write path to the array; the pin itself is never forwarded
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wr_valid <= 1'b0;
			wr_data <= '0;
			wr_byte_en <= '0;
		end else if (clk_en) begin
			wr_valid <= 1'b0;
			if (beat && is_write_kind && (cur_kind == DMBI_OP_WRITE || cur_mask)) begin
				wr_valid <= 1'b1; // see R11 see R20
				wr_data <= lane_wr;
				wr_byte_en <= lane_keep; // see R04
			end
		end
	end

	// Read path to the pins
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			dq_out <= '0;
			dq_oe <= 1'b0;
			mask_invert_out <= '0;
			mask_invert_oe <= '0;
			rd_take <= 1'b0;
		end else if (clk_en) begin
			rd_take <= 1'b0;
			if (op_take) begin
				dq_oe <= op_kind == DMBI_OP_READ || op_kind == DMBI_OP_MODE_REG_READ
					|| op_kind == DMBI_OP_RD_FIFO || op_kind == DMBI_OP_RD_TRAIN;
				mask_invert_oe <= {LANES{next_mi_oe}}; // see R07
				mask_invert_out <= '0;
			end else if (beat && is_read_kind) begin
				dq_out <= lane_rd;
				mask_invert_out <= lane_pin; // see R10 see R18
				rd_take <= cur_kind != DMBI_OP_RD_FIFO;
			end else if (state == DMBI_TAIL && link_edge) begin
				dq_oe <= 1'b0;
				mask_invert_oe <= '0;
				mask_invert_out <= '0;
			end
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence s_wr_beat_low0;
		beat && cur_kind == DMBI_OP_WRITE && cur_winv && !mi_s2[0];
	endsequence

	sequence s_rd_heavy0;
		beat && cur_kind == DMBI_OP_READ && cur_rinv && dmbi_ones(rd_data[7:0]) > `DMBI_RD_INV_ONES;
	endsequence

	sequence s_mw_dbi_mask1;
		beat && cur_kind == DMBI_OP_MASKED_WRITE && cur_mask && cur_winv && !mi_s2[1]
			&& dmbi_ones({2'b00, dq_s2[15:10]}) >= `DMBI_MASK_ONES;
	endsequence

	a_write_inverts: assert property (s_wr_beat_low0 |=> wr_valid && wr_data[7:0] == ~$past(dq_s2[7:0])) // see R09
		else $error("write beat with pin low not inverted");

	a_read_inverts: assert property (s_rd_heavy0 ##1 1'b1 |-> mask_invert_out[0]
		&& dq_out[7:0] == ~$past(rd_data[7:0])) // see R10
		else $error("heavy read byte not inverted");

	a_mask_pin_high: assert property (beat && cur_kind == DMBI_OP_MASKED_WRITE && cur_mask && !cur_winv
		&& mi_s2[0] |=> wr_valid && !wr_byte_en[0]) // see R12
		else $error("masked write beat with pin high was written");

	a_mask_by_count: assert property (s_mw_dbi_mask1 |=> wr_valid && !wr_byte_en[1]) // see R14
		else $error("masked write pattern not masked");

	a_mode_read_low: assert property (state == DMBI_BURST && cur_kind == DMBI_OP_MODE_REG_READ
		&& cur_rinv |-> mask_invert_oe == '1 && mask_invert_out == '0) // see R18
		else $error("mask/invert pin not held low on mode register read");

	a_read_drv_off: assert property (state != DMBI_IDLE && (cur_kind == DMBI_OP_READ
		|| cur_kind == DMBI_OP_MODE_REG_READ) && !cur_rinv |-> mask_invert_oe == '0) // see R07
		else $error("mask/invert driver on with read inversion off");

	a_rx_off: assert property (clk_en && !winv_en && !mask_en |=> !mask_invert_rx_en) // see R06
		else $error("mask/invert receiver left on");

	a_fifo_raw: assert property (beat && cur_kind == DMBI_OP_WR_FIFO |=>
		fifo_mem[$past(fifo_idx)] == {$past(pin_cap), $past(dq_s2)} && !wr_valid) // see R15
		else $error("training capture altered");

	a_illegal_drop: assert property (op_take && op_kind == DMBI_OP_MASKED_WRITE && !mask_en |=>
		illegal_seen && !wr_valid) // see R08
		else $error("illegal masked write not flagged");

	a_normal_nomask: assert property (beat && cur_kind == DMBI_OP_WRITE && !cur_winv |=>
		wr_valid && wr_byte_en == '1 && wr_data == $past(dq_s2)) // see R11
		else $error("normal write altered without write inversion");
endmodule

// ===== rtl/dmbi_defines.svh
/*
 Offsets, field positions, reset values and thresholds of the byte mask and
 bus inversion block. Assumes inclusion by every design file that needs them.
*/
// Overview of operation
// R01: One enable bit switches write-path inversion for normal and masked writes.
// R02: A separate enable bit switches read-path inversion, independent of writes.
// R03: A bit in another mode register switches the byte-mask function for masked writes.
// R04: One mask/invert pin per byte lane, two per channel; decisions per byte.
// R05: Mask/invert pin is two-way DDR, sampled or driven on the data beats.
// R06: Write inversion and masking both off: pin ignored, input receiver off.
// R07: Read inversion off: driver off for reads; all off: off for training too.
// R08: Controller must not issue masked write while the byte-mask function is off.
// R09: Write inversion on: normal write inverts a byte whose pin is sampled low.
// R10: Read inversion on: more than four ones inverts the byte, pin high.
// R11: Masking on, write inversion off: normal write masks nothing, pin held low.
// R12: Masking on, write inversion off: masked-write beat with pin high is dropped.
// R13: Controller uses masked-write command for every write needing a byte masked.
// R14: Both on: pin low and five or more upper-six ones masks the beat.
// R15: Write training FIFO captures the pin as pattern, no masking or inversion.
// R16: Read training FIFO drives back the pin pattern stored earlier.
// R17: Read data training treats the pin as part of the training pattern.
// R18: Mode-register reads apply no inversion; pin driven low when read inversion on.
// R19: Each lane decides from its own eight data bits and its own pin.
// R20: Inversion complements all eight bits; the pin value is never written to the array.
`ifndef DMBI_DEFINES_SVH
`define DMBI_DEFINES_SVH

`define DMBI_REG_INV_MODE 4'h0
`define DMBI_REG_MASK_MODE 4'h4
`define DMBI_REG_STATUS 4'h8

`define DMBI_WINV_BIT 7
`define DMBI_RINV_BIT 6
`define DMBI_MASK_DIS_BIT 5
`define DMBI_INV_MODE_RESET 8'h00
`define DMBI_MASK_MODE_RESET 8'h00

`define DMBI_STAT_BUSY_BIT 0
`define DMBI_STAT_ILLEGAL_BIT 1
`define DMBI_STAT_BEATS_LSB 8
`define DMBI_STAT_BEATS_MSB 13

`define DMBI_RD_INV_ONES 4'h4
`define DMBI_MASK_ONES 4'h5
`define DMBI_DEFAULT_BEATS 6'h10

`endif

// ===== rtl/dmbi_pkg.sv
/*
 Types and shared arithmetic of the byte mask and bus inversion block.
 Assumes nothing of its surroundings.
*/
package dmbi_pkg;
	typedef enum logic [2:0] {
		DMBI_OP_WRITE,
		DMBI_OP_MASKED_WRITE,
		DMBI_OP_READ,
		DMBI_OP_WR_FIFO,
		DMBI_OP_RD_FIFO,
		DMBI_OP_RD_TRAIN,
		DMBI_OP_MODE_REG_READ
	} dmbi_op_type;

	typedef enum {DMBI_IDLE, DMBI_BURST, DMBI_TAIL} dmbi_state_type;

	function automatic logic [3:0] dmbi_ones(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, v[i]};
		end
		return n;
	endfunction
endpackage

// ===== rtl/dmbi_lane.sv
/*
 Per-byte codec: decides masking and inversion of one lane from its own byte
 and its own mask/invert pin. Purely combinational; the caller registers it.
*/
`include "dmbi_defines.svh"

module dmbi_lane
	import dmbi_pkg::*;
(
	input wire dmbi_op_type kind,
	input wire logic winv_en,
	input wire logic rinv_en,
	input wire logic mask_en,
	input wire logic [7:0] wr_byte,
	input wire logic wr_pin,
	input wire logic [7:0] rd_byte,
	input wire logic rd_pattern_pin,
	output logic [7:0] wr_out,
	output logic wr_keep,
	output logic [7:0] rd_out,
	output logic rd_pin
);
	always_comb begin
		wr_out = wr_byte;
		wr_keep = 1'b1;
		rd_out = rd_byte;
		rd_pin = 1'b0;
		case (kind)
			DMBI_OP_WRITE: begin
				// Masking alone never masks a normal write
				if (winv_en && !wr_pin) begin
					wr_out = ~wr_byte; // see R09 see R20
				end
			end
			DMBI_OP_MASKED_WRITE: begin
				if (mask_en && !winv_en) begin
					wr_keep = ~wr_pin; // see R12
				end else if (mask_en && winv_en) begin
					if (!wr_pin && dmbi_ones({2'b00, wr_byte[7:2]}) >= `DMBI_MASK_ONES) begin
						wr_keep = 1'b0; // see R14
					end else if (!wr_pin) begin
						wr_out = ~wr_byte; // see R14
					end
				end else begin
					wr_keep = 1'b0; // see R08
				end
			end
			DMBI_OP_READ: begin
				if (rinv_en && dmbi_ones(rd_byte) > `DMBI_RD_INV_ONES) begin
					rd_out = ~rd_byte; // see R10 see R20
					rd_pin = 1'b1;
				end
			end
			DMBI_OP_RD_FIFO, DMBI_OP_RD_TRAIN: begin
				rd_pin = rd_pattern_pin; // see R16 see R17
			end
			default: begin
			end
		endcase
	end
endmodule

// ===== testbench/dmbi_ctrl_model.sv
/*
 Behavioural memory controller side: makes the link clock and drives data and
 mask/invert pins, one beat per link edge. Assumes the bench calls beat in order.
*/
module dmbi_ctrl_model (
	output logic link_clk,
	output logic [15:0] dq,
	output logic [1:0] mask_invert_pin
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		link_clk = 1'b0;
		dq = 16'h0000;
		mask_invert_pin = 2'h0;
	end

	// Data centred on the edge; the clock stands still between frames
	task automatic beat(input logic [15:0] d, input logic [1:0] p);
		dq = d;
		mask_invert_pin = p;
		#20 link_clk = ~link_clk;
		#20;
	endtask

	// Released lines flip so a stale value is never mistaken for a live one
	task automatic release_bus();
		dq = ~dq;
		mask_invert_pin = ~mask_invert_pin;
	endtask
endmodule

// ===== testbench/tb_top.sv
/*
 Self-checking bench of the byte mask and bus inversion codec. Assumes the
 controller model on the link side and the array side played by the bench.
*/
`include "dmbi_defines.svh"

module tb_top
	import dmbi_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic clk_en = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic op_start = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	dmbi_op_type op_kind = DMBI_OP_WRITE;
	logic [5:0] op_beats = 6'h00;
	logic busy, link_clk, dq_oe, mask_invert_rx_en, wr_valid, rd_take;
	logic [15:0] dq_in, dq_out, wr_data, rd_data;
	logic [1:0] mask_invert_in, mask_invert_out, mask_invert_oe, wr_byte_en, rd_train_pattern;
	logic [15:0] tx_d[16];
	logic [1:0] tx_p[16];
	logic [7:0] b_tab[8] = '{8'hf8, 8'hf3, 8'h0f, 8'h1f, 8'hff, 8'h00, 8'hfc, 8'h5a};
	logic [3:0] rd_idx = 4'h0;
	logic [15:0] wq_d[$], rq_d[$];
	logic [1:0] wq_e[$], rq_p[$], rq_oe[$];
	logic wi, ri, mk;
	int fail_count = 0;
	int num_checks = 0;
	int cycles = 0;

	always #5 clk_sys = ~clk_sys;
	// The array side serves the table entry of the beat not yet taken
	assign rd_data = tx_d[rd_idx];
	assign rd_train_pattern = tx_p[rd_idx];

	dmbi_codec i_dmbi_codec (.clk_sys, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.op_start, .op_kind, .op_beats, .busy, .link_clk, .dq_in, .dq_out, .dq_oe, .mask_invert_in,
		.mask_invert_out, .mask_invert_oe, .mask_invert_rx_en, .wr_valid, .wr_data, .wr_byte_en, .rd_data,
		.rd_train_pattern, .rd_take);
	dmbi_ctrl_model i_dmbi_ctrl_model (.link_clk(link_clk), .dq(dq_in), .mask_invert_pin(mask_invert_in));

	always @(posedge clk_sys) begin
		cycles++;
		if (wr_valid === 1'b1) begin
			wq_d.push_back(wr_data);
			wq_e.push_back(wr_byte_en);
		end
		// Counts consumed array words; a new burst restarts the count
		if (op_start === 1'b1)
			rd_idx <= 4'h0;
		else if (rd_take === 1'b1)
			rd_idx <= rd_idx + 4'h1;
		if (cycles == 30000) begin
			check("timeout", 1, 0);
			stop_test();
		end
	end

	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic wr_reg(logic [3:0] a, logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rd_reg(logic [3:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	task automatic set_mode(logic w, logic r, logic m);
		wi = w;
		ri = r;
		mk = m;
		wr_reg(`DMBI_REG_INV_MODE, {24'h0, w, r, 6'h00});
		wr_reg(`DMBI_REG_MASK_MODE, {26'h0, ~m, 5'h00});
		@(posedge clk_sys);
		#1 check("rx_en", mask_invert_rx_en, w | m);
	endtask

	// Reads give one extra edge for the tail; the controller drives the complemented table data on dq then
	task automatic run(dmbi_op_type k, int n, logic rd);
		logic [1:0] p;
		wq_d.delete();
		wq_e.delete();
		rq_d.delete();
		rq_p.delete();
		rq_oe.delete();
		@(posedge clk_sys);
		op_start <= 1'b1;
		op_kind <= k;
		op_beats <= 6'(n);
		@(posedge clk_sys);
		op_start <= 1'b0;
		#3 check("busy start", busy, 1);
		check("dq_oe start", dq_oe, rd);
		for (int i = 0; i < n + 32'(rd); i++) begin
			p = (k == DMBI_OP_WRITE && mk && !wi) ? 2'h0 : tx_p[i];
			if (rd)
				i_dmbi_ctrl_model.beat(~tx_d[i], ~tx_p[i]);
			else
				i_dmbi_ctrl_model.beat(tx_d[i], p);
			// The previous beat's read output stands from 33 ns before to 7 ns after this point
			if (rd && i > 0) begin
				rq_d.push_back(dq_out);
				rq_p.push_back(mask_invert_out);
				rq_oe.push_back(mask_invert_oe);
			end
		end
		i_dmbi_ctrl_model.release_bus();
		for (int i = 0; i < 40 && busy !== 1'b0; i++)
			@(posedge clk_sys);
		// Step past the edge so the sampler has taken the last write beat
		#1 check("busy end", busy, 0);
		check("dq_oe end", dq_oe, 0);
		check("pin oe end", mask_invert_oe, 0);
	endtask

	function automatic logic [8:0] exp_wr(logic masked, logic [7:0] b, logic p);
		if (masked && !wi)
			return {!p, b};
		if (masked && !p && $countones(b[7:2]) >= 5)
			return {1'b0, b};
		return {1'b1, (wi && !p) ? ~b : b};
	endfunction

	task automatic cmp_wr(logic masked, int n);
		logic [8:0] e;
		check("wr beats", wq_d.size(), n);
		for (int i = 0; i < n; i++) begin
			for (int l = 0; l < 2; l++) begin
				e = exp_wr(masked, tx_d[i][8*l+:8], tx_p[i][l]);
				check("byte_en", wq_e[i][l], e[8]);
				if (e[8])
					check("wr_data", wq_d[i][8*l+:8], e[7:0]);
			end
		end
	endtask

	task automatic cmp_rd(dmbi_op_type k, int n);
		logic [8:0] e;
		logic oe;
		oe = (k == DMBI_OP_READ || k == DMBI_OP_MODE_REG_READ) ? ri : (wi | ri | mk);
		check("rd beats", rq_d.size(), n);
		check("rd_take", rd_idx, (k == DMBI_OP_RD_FIFO) ? 0 : n);
		for (int i = 0; i < n; i++) begin
			for (int l = 0; l < 2; l++) begin
				e = {1'b0, tx_d[i][8*l+:8]};
				if (k == DMBI_OP_RD_FIFO || k == DMBI_OP_RD_TRAIN)
					e[8] = tx_p[i][l];
				else if (k == DMBI_OP_READ && ri && $countones(e[7:0]) > 4)
					e = {1'b1, ~e[7:0]};
				check("rd_oe", rq_oe[i][l], oe);
				check("rd_data", rq_d[i][8*l+:8], e[7:0]);
				if (oe)
					check("rd_pin", rq_p[i][l], e[8]);
			end
		end
	endtask

	task automatic t_regs();
		logic [31:0] v;
		rd_reg(`DMBI_REG_INV_MODE, v);
		check("inv reset", v, 32'h0);
		rd_reg(`DMBI_REG_MASK_MODE, v);
		check("mask reset", v, 32'h0);
		// A write while the clock enable is low must leave the mode untouched
		@(posedge clk_sys);
		clk_en <= 1'b0;
		wr_reg(`DMBI_REG_INV_MODE, 32'h0000_00c0);
		clk_en <= 1'b1;
		rd_reg(`DMBI_REG_INV_MODE, v);
		check("frozen write", v, 32'h0);
		wr_reg(4'hc, 32'hffff_ffff);
		rd_reg(4'hc, v);
		check("unmapped", v, 32'h0);
		$display("test regs done");
	endtask

	task automatic t_write();
		for (int c = 0; c < 4; c++) begin
			set_mode(c[1], 1'b0, c[0]);
			run(DMBI_OP_WRITE, 8, 1'b0);
			cmp_wr(1'b0, 8);
		end
		for (int c = 0; c < 2; c++) begin
			set_mode(c[0], 1'b0, 1'b1);
			run(DMBI_OP_MASKED_WRITE, 8, 1'b0);
			cmp_wr(1'b1, 8);
		end
		$display("test write done");
	endtask

	task automatic t_illegal();
		logic [31:0] v;
		set_mode(1'b1, 1'b0, 1'b0);
		run(DMBI_OP_MASKED_WRITE, 4, 1'b0);
		check("illegal beats", wq_d.size(), 0);
		rd_reg(`DMBI_REG_STATUS, v);
		check("illegal flag", v[`DMBI_STAT_ILLEGAL_BIT], 1);
		wr_reg(`DMBI_REG_STATUS, 32'h2);
		rd_reg(`DMBI_REG_STATUS, v);
		check("flag clear", v[`DMBI_STAT_ILLEGAL_BIT], 0);
		$display("test illegal done");
	endtask

	task automatic t_read();
		for (int r = 0; r < 2; r++) begin
			set_mode(1'b1, r[0], 1'b1);
			run(DMBI_OP_READ, 8, 1'b1);
			cmp_rd(DMBI_OP_READ, 8);
			run(DMBI_OP_MODE_REG_READ, 8, 1'b1);
			cmp_rd(DMBI_OP_MODE_REG_READ, 8);
		end
		$display("test read done");
	endtask

	task automatic t_train();
		set_mode(1'b1, 1'b0, 1'b0);
		run(DMBI_OP_WR_FIFO, 8, 1'b0);
		check("fifo wr beats", wq_d.size(), 0);
		run(DMBI_OP_RD_FIFO, 8, 1'b1);
		cmp_rd(DMBI_OP_RD_FIFO, 8);
		set_mode(1'b0, 1'b1, 1'b0);
		run(DMBI_OP_RD_TRAIN, 8, 1'b1);
		cmp_rd(DMBI_OP_RD_TRAIN, 8);
		set_mode(1'b0, 1'b0, 1'b0);
		run(DMBI_OP_RD_FIFO, 8, 1'b1);
		cmp_rd(DMBI_OP_RD_FIFO, 8);
		$display("test train done");
	endtask

	initial begin
		for (int i = 0; i < 16; i++) begin
			tx_d[i] = {b_tab[(i + 3) % 8], b_tab[i % 8]};
			tx_p[i] = 2'(i) ^ 2'(i >> 2);
		end
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		check("rx_en reset", mask_invert_rx_en, 1);
		t_regs();
		t_write();
		t_illegal();
		t_read();
		t_train();
		stop_test();
	end
endmodule
